// ### crb_pkg.sv
// shared constants and types for the conversion result buffer
package crb_pkg;

    ////////////////////////////////////////////////////////////////////////
    // buffer geometry
    localparam int          DEPTH      = 64;    // result locations
    localparam int          PTR_W      = 6;     // pointer width
    localparam int          CNT_W      = 7;     // fill count width, 0..64
    localparam int          RES_W      = 12;    // converter result width
    localparam int          ENTRY_W    = 13;    // tag plus result
    localparam logic [6:0]  CNT_FULL   = 7'h40; // count when every slot used
    localparam logic [6:0]  CNT_ONE    = 7'h01; // count of one entry
    localparam logic [6:0]  CNT_ZERO   = 7'h00;

    ////////////////////////////////////////////////////////////////////////
    // read word layout
    localparam int          WORD_W     = 16;
    localparam int          FULL_BIT   = 15;    // buffer_full_flag
    localparam int          EMPTY_BIT  = 14;    // buffer_empty_flag
    localparam int          TAG_BIT    = 12;    // source_tag_bit
    localparam logic [15:0] WORD_RESET = 16'h4000; // empty set, full clear

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets on the bus
    localparam logic [7:0]  OFS_READ_WORD = 8'h00; // result_buffer_read_word
    localparam logic [7:0]  OFS_CTRL      = 8'h04; // mode and enable
    localparam logic [7:0]  OFS_LEVEL     = 8'h08; // fill level and flags
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0C; // sticky events
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h10; // event enables

    // control register fields
    localparam int          CTRL_EN_BIT   = 0;  // buffer mode enable
    localparam int          CTRL_MODE_LO  = 1;  // scan mode, 3 bits
    localparam int          CTRL_SEL_LO   = 4;  // auto scan select, 3 bits
    localparam logic [6:0]  CTRL_RESET    = 7'h00;
    localparam int          CTRL_W        = 7;

    // interrupt event bits
    localparam int          IRQ_W         = 3;
    localparam int          IRQ_DATA_BIT  = 0;  // result stored
    localparam int          IRQ_FULL_BIT  = 1;  // buffer became full
    localparam int          IRQ_OVF_BIT   = 2;  // result dropped, full
    localparam logic [2:0]  IRQ_RESET     = 3'h0;

    // bus encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // scan modes, in control register encoding order
    typedef enum logic [2:0] {
        SCAN_XY,        // Y then X
        SCAN_XYZ,       // Y, X, first then second pressure
        SCAN_Z,         // first then second pressure
        SCAN_AUTO,      // selected ones of first aux, second aux, temperature
        SCAN_PORT       // battery, first aux, second aux
    } crb_scan_e;

    // result sources
    typedef enum logic [2:0] {
        SRC_X, SRC_Y, SRC_Z1, SRC_Z2, SRC_BAT, SRC_FIRST_AUXILIARY_INPUT, SRC_SECOND_AUXILIARY_INPUT, SRC_TEMP
    } crb_src_e;

endpackage : crb_pkg

// ### crb_scan_seq.sv
// labels each converter result with its source by scan mode order
`timescale 1ns/1ps
`default_nettype none
module crb_scan_seq (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               scan_start,  // new scan begins
    input  wire logic               res_valid,   // one result arrives
    input  wire logic [2:0]         scan_mode,   // crb_scan_e encoding
    input  wire logic [2:0]         auto_sel,    // first_auxiliary_input, second_auxiliary_input, temp
    output logic                    res_tag,     // source_tag_bit
    output crb_pkg::crb_src_e       res_src      // source of this result
);

    logic [1:0] pos_q;  // position of next result in the scan

    // tag is one for Y, second pressure, first aux and temperature
    function automatic logic tag_of(input crb_pkg::crb_src_e s);
        tag_of = (s == crb_pkg::SRC_Y) || (s == crb_pkg::SRC_Z2) ||
                 (s == crb_pkg::SRC_FIRST_AUXILIARY_INPUT) || (s == crb_pkg::SRC_TEMP);
    endfunction : tag_of

    // n-th selected entry of the auto list, skipping unselected inputs
    function automatic crb_pkg::crb_src_e auto_pick(input logic [1:0] n,
                                                   input logic [2:0] sel);
        logic [1:0] cnt;
        crb_pkg::crb_src_e lst [3];
        cnt       = 2'h0;
        lst[0]    = crb_pkg::SRC_FIRST_AUXILIARY_INPUT;
        lst[1]    = crb_pkg::SRC_SECOND_AUXILIARY_INPUT;
        lst[2]    = crb_pkg::SRC_TEMP;
        auto_pick = crb_pkg::SRC_TEMP;
        for (int i = 2; i >= 0; i--) begin
            if (sel[i]) begin
                auto_pick = lst[i];
            end
        end
        for (int i = 0; i < 3; i++) begin
            if (sel[i]) begin
                if (cnt == n) begin
                    auto_pick = lst[i];
                end
                cnt = cnt + 2'h1;
            end
        end
    endfunction : auto_pick

    ////////////////////////////////////////////////////////////////////////
    // source of the result at the current position
    always_comb begin
        case (crb_pkg::crb_scan_e'(scan_mode))
            crb_pkg::SCAN_XY:
                res_src = pos_q[0] ? crb_pkg::SRC_X : crb_pkg::SRC_Y;
            crb_pkg::SCAN_XYZ: begin
                case (pos_q)
                    2'h0:    res_src = crb_pkg::SRC_Y;
                    2'h1:    res_src = crb_pkg::SRC_X;
                    2'h2:    res_src = crb_pkg::SRC_Z1;
                    default: res_src = crb_pkg::SRC_Z2;
                endcase
            end
            crb_pkg::SCAN_Z:
                res_src = pos_q[0] ? crb_pkg::SRC_Z2 : crb_pkg::SRC_Z1;
            crb_pkg::SCAN_AUTO:
                res_src = auto_pick(pos_q, auto_sel);
            crb_pkg::SCAN_PORT: begin
                case (pos_q)
                    2'h0:    res_src = crb_pkg::SRC_BAT;
                    2'h1:    res_src = crb_pkg::SRC_FIRST_AUXILIARY_INPUT;
                    default: res_src = crb_pkg::SRC_SECOND_AUXILIARY_INPUT;
                endcase
            end
            default: res_src = crb_pkg::SRC_X;
        endcase
        res_tag = tag_of(res_src);
    end

    ////////////////////////////////////////////////////////////////////////
    // position advances per result, restarts with each scan
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pos_q <= 2'h0;
        end else if (scan_start) begin
            pos_q <= 2'h0;
        end else if (res_valid) begin
            pos_q <= pos_q + 2'h1;  // wraps after four, longest scan
        end
    end

endmodule : crb_scan_seq
`default_nettype wire

// ### crb_irq.sv
// sticky event status, mask and one level interrupt
`timescale 1ns/1ps
`default_nettype none
module crb_irq (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic [2:0]         evt,        // one-cycle events
    input  wire logic               stat_rd,    // status read, clears
    input  wire logic               mask_wr,    // mask write strobe
    input  wire logic [2:0]         mask_wdata, // new mask value
    output logic      [2:0]         stat_q,     // sticky status
    output logic      [2:0]         mask_q,     // mask, one enables
    output logic                    irq_q       // level interrupt
);

    logic [2:0] stat_d;

    // read clears, but an event in the same cycle still sets: set wins
    always_comb begin
        stat_d = (stat_rd ? crb_pkg::IRQ_RESET : stat_q) | evt;
    end

    ////////////////////////////////////////////////////////////////////////
    // status flops
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stat_q <= crb_pkg::IRQ_RESET;
        end else begin
            stat_q <= stat_d;
        end
    end

    // mask flops
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mask_q <= crb_pkg::IRQ_RESET;
        end else if (mask_wr) begin
            mask_q <= mask_wdata;
        end
    end

    // registered output, one cycle behind status
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q);
        end
    end

endmodule : crb_irq
`default_nettype wire

// ### crb_top.sv
// conversion result buffer: 64-entry store, read port and bus slave
//
// Behaviour
// - reset word: full clear, empty set
// - buffer mode stores every converter result; a result arriving with all 64 unread and no pop is dropped
// - result right-justified, flags in upper nibble
// - full flag when all 64 unread
// - empty flag in word reading last entry
// - tag zero X/Z1/battery/second_auxiliary_input, else one
// - coordinate scan writes Y then X
// - coordinate-pressure scan writes Y,X,Z1,Z2
// - pressure scan writes first then second
// - auto scan: selected first_auxiliary_input, second_auxiliary_input, temperature
// - port scan: battery, first_auxiliary_input, second_auxiliary_input
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module crb_top (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // converter side
    input  wire logic               scan_start,  // start of a scan
    input  wire logic               conv_valid,  // result strobe
    input  wire logic [11:0]        conv_result, // conversion_result
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // interrupt
    output logic                    irq
);

    ////////////////////////////////////////////////////////////////////////
    // storage and pointers
    logic [crb_pkg::ENTRY_W-1:0] mem_q [crb_pkg::DEPTH]; // tag and result
    logic [crb_pkg::PTR_W-1:0]   wr_ptr_q;               // next free slot
    logic [crb_pkg::PTR_W-1:0]   rd_ptr_q;               // oldest unread
    logic [crb_pkg::CNT_W-1:0]   count_q;                // unread entries

    // bus state
    logic                        wr_pend_q;   // write data phase due
    logic [7:0]                  wr_addr_q;   // its address
    logic [31:0]                 hrdata_q;    // read data

    // control
    logic [crb_pkg::CTRL_W-1:0]  ctrl_q;      // enable, mode, select

    // decoded access
    logic                        acc;         // address phase taken
    logic                        rd_acc;      // read taken
    logic [7:0]                  acc_ofs;     // word-aligned offset
    logic                        pop;         // read of result word
    logic                        push;        // result stored
    logic                        drop;        // result lost, full
    logic                        became_full; // fill hits 64
    logic                        tag;         // from sequencer
    crb_pkg::crb_src_e           src;         // from sequencer
    logic [crb_pkg::WORD_W-1:0]  word_now;    // word for this pop
    logic [2:0]                  stat;        // sticky status
    logic [2:0]                  mask;        // mask register
    logic [2:0]                  evt;         // events this cycle
    logic                        mask_wr;     // mask write strobe

    ////////////////////////////////////////////////////////////////////////
    // formats one read word from flags and an entry
    function automatic logic [15:0] make_word(
        input logic                       full,
        input logic                       empty,
        input logic [crb_pkg::ENTRY_W-1:0] ent);
        logic [15:0] w;
        w                                 = 16'h0000;
        w[crb_pkg::FULL_BIT]              = full;
        w[crb_pkg::EMPTY_BIT]             = empty;
        w[crb_pkg::TAG_BIT]               = ent[crb_pkg::RES_W];
        w[crb_pkg::RES_W-1:0]             = ent[crb_pkg::RES_W-1:0];
        make_word                         = w;
    endfunction : make_word

    ////////////////////////////////////////////////////////////////////////
    // source labelling by scan order
    crb_scan_seq u_seq (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .scan_start (scan_start),
        .res_valid  (conv_valid),
        .scan_mode  (ctrl_q[crb_pkg::CTRL_MODE_LO +: 3]),
        .auto_sel   (ctrl_q[crb_pkg::CTRL_SEL_LO +: 3]),
        .res_tag    (tag),
        .res_src    (src)
    );

    ////////////////////////////////////////////////////////////////////////
    // address phase decode; slave never inserts wait states
    always_comb begin
        acc     = hsel && hready && (htrans == crb_pkg::HTRANS_NONSEQ);
        rd_acc  = acc && !hwrite;
        acc_ofs = {haddr[7:2], 2'h0};
        pop     = rd_acc && (acc_ofs == crb_pkg::OFS_READ_WORD)
                  && (count_q != crb_pkg::CNT_ZERO);
        mask_wr = wr_pend_q && (wr_addr_q == crb_pkg::OFS_IRQ_MASK);
    end

    // push unless full, but a pop in the same cycle frees a slot
    always_comb begin
        push = conv_valid && ctrl_q[crb_pkg::CTRL_EN_BIT]
               && ((count_q != crb_pkg::CNT_FULL) || pop);
        drop = conv_valid && ctrl_q[crb_pkg::CTRL_EN_BIT] && !push;
        became_full = push && !pop
                      && (count_q == crb_pkg::CNT_FULL - crb_pkg::CNT_ONE);
        evt = 3'h0;
        evt[crb_pkg::IRQ_DATA_BIT] = push;
        evt[crb_pkg::IRQ_FULL_BIT] = became_full;
        evt[crb_pkg::IRQ_OVF_BIT]  = drop;
    end

    // word handed out by a pop: flags describe the fill at read time
    always_comb begin
        word_now = make_word(count_q == crb_pkg::CNT_FULL,
                             count_q == crb_pkg::CNT_ONE,
                             mem_q[rd_ptr_q]);
    end

    ////////////////////////////////////////////////////////////////////////
    // result store; no reset on the array keeps it plain RAM
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_ptr_q] <= {tag, conv_result};
        end
    end

    // write pointer, wraps naturally at 64
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= wr_ptr_q + 6'h01;
        end
    end

    // read pointer moves only on a real pop
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= rd_ptr_q + 6'h01;
        end
    end

    // unread count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_q <= crb_pkg::CNT_ZERO;
        end else if (push && !pop) begin
            count_q <= count_q + crb_pkg::CNT_ONE;
        end else if (pop && !push) begin
            count_q <= count_q - crb_pkg::CNT_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write data phase bookkeeping
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= acc && hwrite;
            if (acc) begin
                wr_addr_q <= acc_ofs;
            end
        end
    end

    // control register, written in the data phase
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q <= crb_pkg::CTRL_RESET;
        end else if (wr_pend_q && (wr_addr_q == crb_pkg::OFS_CTRL)) begin
            ctrl_q <= hwdata[crb_pkg::CTRL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, captured at the address phase edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata_q <= crb_pkg::DATA_ZERO;
        end else if (rd_acc) begin
            case (acc_ofs)
                crb_pkg::OFS_READ_WORD: begin
                    if (pop) begin
                        hrdata_q <= {16'h0000, word_now};
                    end else begin  // nothing unread
                        hrdata_q <= {16'h0000, crb_pkg::WORD_RESET};
                    end
                end
                crb_pkg::OFS_CTRL:
                    hrdata_q <= {25'h0000000, ctrl_q};
                crb_pkg::OFS_LEVEL:
                    hrdata_q <= {14'h0000, count_q == crb_pkg::CNT_FULL,
                                 count_q == crb_pkg::CNT_ZERO,
                                 9'h000, count_q};
                crb_pkg::OFS_IRQ_STAT:
                    hrdata_q <= {29'h00000000, stat};
                crb_pkg::OFS_IRQ_MASK:
                    hrdata_q <= {29'h00000000, mask};
                default:
                    hrdata_q <= crb_pkg::DATA_ZERO;  // unmapped reads zero
            endcase
        end
    end

    // zero-wait slave, always OKAY
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event status and interrupt
    crb_irq u_irq (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .evt        (evt),
        .stat_rd    (rd_acc && (acc_ofs == crb_pkg::OFS_IRQ_STAT)),
        .mask_wr    (mask_wr),
        .mask_wdata (hwdata[crb_pkg::IRQ_W-1:0]),
        .stat_q     (stat),
        .mask_q     (mask),
        .irq_q      (irq)
    );

    assign hrdata = hrdata_q;

endmodule : crb_top
`default_nettype wire

// ### crb_top_sva.sv
// port checker for the conversion result buffer
`timescale 1ns/1ps
`default_nettype none
module crb_top_sva (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        conv_valid,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // shadow fill count; word flags must agree with it
    logic       take, pop, store, rd_w, rd_l, wr_d; // decoded phases
    logic       dp_q, wr_q, en_q;       // data phase, direction, enable
    logic [7:0] ofs_q;                  // offset of the data phase
    logic [6:0] cnt_q, at_q;            // fill now, fill at the access
    logic [2:0] msk_q;                  // shadow interrupt mask
    assign take  = hsel && hready && htrans == crb_pkg::HTRANS_NONSEQ;
    assign pop   = take && !hwrite && haddr[7:0] == crb_pkg::OFS_READ_WORD
                   && cnt_q != crb_pkg::CNT_ZERO;
    // a pop on the same edge makes room at full
    assign store = conv_valid && en_q && (cnt_q != crb_pkg::CNT_FULL || pop);
    assign rd_w  = dp_q && !wr_q && ofs_q == crb_pkg::OFS_READ_WORD;
    assign rd_l  = dp_q && !wr_q && ofs_q == crb_pkg::OFS_LEVEL;
    assign wr_d  = dp_q && wr_q;
    // bus phase tracking
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {dp_q, wr_q, ofs_q, at_q} <= '0;
        end else begin
            dp_q  <= take;
            wr_q  <= hwrite;
            ofs_q <= haddr[7:0];
            at_q  <= take ? cnt_q : at_q;
        end
    end
    // shadow state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {cnt_q, en_q, msk_q} <= '0;
        end else begin
            cnt_q <= cnt_q + {6'h00, store} - {6'h00, pop};
            if (wr_d && ofs_q == crb_pkg::OFS_CTRL) en_q <= hwdata[0];
            if (wr_d && ofs_q == crb_pkg::OFS_IRQ_MASK) msk_q <= hwdata[2:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    chk_empty_word: assert property (
        rd_w && at_q == 7'h00 |-> hrdata == {16'h0000, crb_pkg::WORD_RESET})
        else $error("empty store read gave a wrong word");
    chk_full_flag: assert property (
        rd_w |-> hrdata[15] == (at_q == crb_pkg::CNT_FULL))
        else $error("full flag disagrees with fill");
    chk_empty_flag: assert property (
        rd_w |-> hrdata[14] == (at_q <= crb_pkg::CNT_ONE))
        else $error("empty flag disagrees with fill");
    chk_upper_zero: assert property (
        rd_w |-> hrdata[31:16] == 16'h0000 && !hrdata[13])
        else $error("unused word bits not zero");
    chk_level_count: assert property (rd_l |-> hrdata[6:0] == at_q)
        else $error("fill level disagrees with results stored");
    chk_level_flags: assert property (
        rd_l |-> hrdata[17:16] == {at_q == 7'h40, at_q == 7'h00})
        else $error("level flags disagree with fill");
    // irq lags the mask by a cycle
    chk_irq_masked: assert property (irq |-> (msk_q | $past(msk_q)) != 3'h0)
        else $error("interrupt raised with all events masked");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered with an error");
    cov_full_read: cover property (rd_w && at_q == crb_pkg::CNT_FULL);
    cov_last_read: cover property (rd_w && at_q == crb_pkg::CNT_ONE);
    cov_irq_rise:  cover property ($rose(irq));
endmodule : crb_top_sva
`default_nettype wire

// ### crb_host_model.sv
// host model: single-word bus master reading the result buffer
`timescale 1ns/1ps
`default_nettype none
module crb_host_model (
    input  wire logic        clk_sys,
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    // idle, selected bus at time zero
    initial {hsel, hsize, haddr, htrans, hwrite, hwdata} = {1'b1, 3'h2, 67'h0};
    // one transfer; ok low if a phase waits 50 cycles
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output bit ok);
        @(posedge clk_sys);
        {haddr, hwrite, htrans} <= {a, w, crb_pkg::HTRANS_NONSEQ};
        for (int p = 0; p < 2; p++) begin
            ok = 1'b0;
            for (int n = 0; n < 50 && !ok; n++) begin
                @(posedge clk_sys);
                ok = hready === 1'b1;
            end
            if (!ok) return;
            // address taken: data phase next
            if (p == 0) {htrans, hwdata} <= {2'h0, wd};
        end
        rd = hrdata;
    endtask : xfer
endmodule : crb_host_model
`default_nettype wire

// ### crb_top_tb_top.sv
// self-checking bench for the conversion result buffer
`timescale 1ns/1ps
`default_nettype none
module crb_top_tb_top;
    typedef struct packed {logic [2:0] mode, sel, n;
        logic [3:0] tags;} crb_row_s;
    logic             clk_sys, rst, scan_start, conv_valid;
    logic      [11:0] conv_result;
    logic      [31:0] d, e;           // read word, expected word
    wire logic        hsel, hwrite, hreadyout, hresp, irq;
    wire logic [1:0]  htrans;
    wire logic [2:0]  hsize;
    wire logic [31:0] haddr, hwdata, hrdata;
    int               num_errors, checks_done;
    // tags lsb first: Y1 X0, Z1 0 Z2 1, first_auxiliary_input 1 second_auxiliary_input 0 temp 1, bat 0
    crb_row_s rows [6] = '{
        '{3'h0, 3'h0, 3'h2, 4'h1}, '{3'h1, 3'h0, 3'h4, 4'h9},
        '{3'h2, 3'h0, 3'h2, 4'h2}, '{3'h3, 3'h7, 3'h3, 4'h5},
        '{3'h3, 3'h6, 3'h2, 4'h2}, '{3'h4, 3'h0, 3'h3, 4'h2}};
    always #2 clk_sys = ~clk_sys;     // 4 ns period
    crb_top u_dut (.clk_sys(clk_sys), .rst(rst), .scan_start(scan_start),
        .conv_valid(conv_valid), .conv_result(conv_result), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
    crb_host_model u_host (.clk_sys(clk_sys), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata));
    // compare one word
    task automatic check(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // counts, verdict, end of run
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    // one bus transfer; a hang fails the run
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] wd);
        bit ok;
        u_host.xfer({24'h000000, a}, w, wd, d, ok);
        if (!ok) begin
            num_errors++;
            $display("BAD t=%0t bus timeout", $time);
            test_done();
        end
    endtask : bus
    // one converter result, or with s set a scan restart
    task automatic conv(input logic [11:0] r, input bit s = 1'b0);
        @(posedge clk_sys);
        {scan_start, conv_valid, conv_result} <= {s, ~s, r};
        @(posedge clk_sys);
        {scan_start, conv_valid} <= 2'h0;
    endtask : conv
    ////////////////////////////////////////////////////////////////////////
    initial begin
        // clock low, reset held, strobes quiet
        {clk_sys, rst, scan_start, conv_valid, conv_result} = {4'h4, 12'h000};
        {num_errors, checks_done} = '0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        bus(crb_pkg::OFS_READ_WORD, 1'b0, '0);
        check(d, {16'h0000, crb_pkg::WORD_RESET});
        bus(crb_pkg::OFS_LEVEL, 1'b0, '0);
        check(d, 32'h0001_0000);
        bus(8'h20, 1'b0, '0);
        check(d, 32'h0000_0000);
        // each scan mode: fill, read back in order
        for (int r = 0; r < 6; r++) begin
            bus(crb_pkg::OFS_CTRL, 1'b1,
                {25'h0, rows[r].sel, rows[r].mode, 1'b1});
            conv('0, 1'b1);
            for (int k = 0; k < rows[r].n; k++)
                conv(12'h3C0 + 12'(16 * r + k));
            for (int k = 0; k < rows[r].n; k++) begin
                bus(crb_pkg::OFS_READ_WORD, 1'b0, '0);
                e = {17'h0, k == rows[r].n - 1, 1'b0, rows[r].tags[k],
                     12'h3C0 + 12'(16 * r + k)};
                check(d, e);
            end
        end
        // fill 64, overflow one with its event unmasked
        bus(crb_pkg::OFS_CTRL, 1'b1, 32'h0000_0001);
        conv('0, 1'b1);
        for (int k = 0; k < 64; k++) conv(12'(3 * k));
        bus(crb_pkg::OFS_LEVEL, 1'b0, '0);
        check(d, 32'h0002_0040);
        check(32'(irq), 32'h0);
        bus(crb_pkg::OFS_IRQ_MASK, 1'b1, 32'h0000_0004);
        bus(crb_pkg::OFS_IRQ_MASK, 1'b0, '0);
        check(d, 32'h4);
        conv(12'hFFF);
        @(posedge clk_sys);
        #1 check(32'(irq), 32'h1);
        bus(crb_pkg::OFS_IRQ_STAT, 1'b0, '0);
        check(d, 32'h0000_0007);
        @(posedge clk_sys);
        #1 check(32'(irq), 32'h0);
        // drain: full first, empty last
        for (int k = 0; k < 64; k++) begin
            bus(crb_pkg::OFS_READ_WORD, 1'b0, '0);
            e = {16'h0, k == 0, k == 63, 1'b0, k[0] == 1'b0, 12'(3 * k)};
            check(d, e);
        end
        bus(crb_pkg::OFS_READ_WORD, 1'b0, '0);
        check(d, 32'h0000_4000);
        // buffer mode off: nothing kept
        bus(crb_pkg::OFS_CTRL, 1'b1, 32'h0000_0000);
        conv(12'h123);
        bus(crb_pkg::OFS_READ_WORD, 1'b0, '0);
        check(d, 32'h0000_4000);
        test_done();
    end
endmodule : crb_top_tb_top
bind crb_top crb_top_sva u_sva (.clk_sys(clk_sys), .rst(rst),
    .conv_valid(conv_valid), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
`default_nettype wire
